// File: rtl/rwpc_map.vh
// register offsets, field positions, reset values and timing constants
`ifndef RWPC_MAP_VH
`define RWPC_MAP_VH
`define RWPC_OFS_CLK_MODE 8'h03
`define RWPC_OFS_MISC 8'h08
`define RWPC_OFS_EOSC 8'h0A
`define RWPC_OFS_STATUS 8'h20
`define RWPC_OFS_WAKE_CFG 8'h21
`define RWPC_CLK_MODE_RST 8'hF6
`define RWPC_MISC_RST 8'h00
`define RWPC_EOSC_RST 8'h00
`define RWPC_WAKE_CFG_RST 8'h00
`define RWPC_CM_PIN_SEL 0
`define RWPC_CM_WDT_EN 1
`define RWPC_CM_LRC_EN 2
`define RWPC_CM_HRC_EN 4
`define RWPC_MISC_WDT_LO 0
`define RWPC_MISC_WDT_HI 1
`define RWPC_MISC_LVR_DIS 2
`define RWPC_MISC_BIAS_EN 4
`define RWPC_EOSC_BG_PD 0
`define RWPC_EOSC_TYPE_LO 5
`define RWPC_EOSC_TYPE_HI 6
`define RWPC_EOSC_XTAL_EN 7
`define RWPC_EOSC_WMASK 8'hE1
`define RWPC_MISC_WMASK 8'h17
`define RWPC_WDT_W 18
`define RWPC_WDT_P0 18'h01FFF
`define RWPC_WDT_P1 18'h03FFF
`define RWPC_WDT_P2 18'h0FFFF
`define RWPC_WDT_P3 18'h3FFFF
`define RWPC_RST_HOLD 4'h8
`define RWPC_CAUSE_POR 0
`define RWPC_CAUSE_LVR 1
`define RWPC_CAUSE_WDT 2
`define RWPC_CAUSE_PIN 3
`define RWPC_CAUSE_RST 4'h1
`endif

// File: rtl/rwpc_sync2.v
// two-stage level synchroniser
`timescale 1ns/10ps
module rwpc_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // level
  input wire d,
  output wire q
);
  reg s1_r;
  reg s2_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

// File: rtl/rwpc_wdt.v
// watchdog counter on low-speed rc ticks
`timescale 1ns/10ps
`include "rwpc_map.vh"
module rwpc_wdt #(
  parameter W = `RWPC_WDT_W
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire enable,
  input wire clear,
  input wire [1:0] period_sel,
  // status
  output reg expire,
  output wire [W-1:0] count
);
  reg [W-1:0] cnt_r;
  reg [W-1:0] limit;
  always @* begin
    case (period_sel)
      2'b00: limit = `RWPC_WDT_P0;
      2'b01: limit = `RWPC_WDT_P1;
      2'b10: limit = `RWPC_WDT_P2;
      default: limit = `RWPC_WDT_P3;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (clear) begin
        cnt_r <= {W{1'b0}};
      end else if (enable && tick) begin
        if (cnt_r >= limit) begin
          cnt_r <= {W{1'b0}};
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign count = cnt_r;
endmodule

// File: rtl/rwpc_top.v
// reset, watchdog and power-mode controller
// Contract
// - power-on, low-voltage, watchdog and pin resets merge into one reset.
// - any system reset forces pc to zero and registers to defaults.
// - power-on and low-voltage resets mark data memory undefined.
// - watchdog and pin resets keep data memory contents.
// - supply under threshold raises a system reset.
// - oscillator setting bit 0 powers down bandgap and voltage detector.
// - misc bit 2 set suppresses low-voltage resets.
// - oscillator bit 7 enables crystal, bits 6..5 its type.
// - misc bit 4 enables the half-supply bias generator.
// - misc bits 1..0 pick watchdog period 8k,16k,64k,256k.
// - watchdog counts only low-speed rc ticks, stops with it off.
// - watchdog clears on power-on and on watchdog-clear instruction.
// - watchdog reaching its period resets the system.
// - clock mode bit 1 watchdog enable, bit 2 rc enable.
// - clock mode bit 0 selects shared pin as reset input.
// - with pin function selected, low pin level resets the system.
// - power-save gates system clock only, oscillators stay on; the code also turns program memory off (PROG_MEM_ON low).
// - in power-save timers on system clock or dead oscillator stop.
// - in power-save a non-system-clock timer match wakes.
// - comparator wakes only with control bit 7 and select bit 6.
// - pin toggle wakes if input enabled, plus direction in power-save.
// - power-down stops every oscillator, keeps sram and registers.
// - timer wake in power-save only, pins in both power-save and power-down.
// - after wake the cpu continues after sleep, no reset.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`include "rwpc_map.vh"
module rwpc_top #(
  parameter NPIN = 8
) (
  // clock and reset
  input wire CLK_SYS,
  input wire ARST_N,
  // avalon-mm slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // reset sources
  input wire POR_N,
  input wire LOW_VOLTAGE_DET,
  input wire LOW_SPEED_RC_TICK,
  input wire SHARED_RESET_IO_PIN,
  // cpu side
  input wire WDT_CLEAR,
  input wire SLEEP_SAVE,
  input wire SLEEP_DOWN,
  output reg SYS_RESET,
  output reg PC_RESET_ZERO,
  output reg DMEM_UNDEFINED,
  output reg CPU_HALT,
  output reg CPU_RESUME,
  // clock and power control
  output reg SYSTEM_CLOCK_GATE_N,
  output reg PROG_MEM_ON,
  output reg LOW_SPEED_RC_ON,
  output reg HIGH_SPEED_RC_ON,
  output reg XTAL_ON,
  output reg [1:0] XTAL_TYPE,
  output reg BANDGAP_PD,
  output reg BIAS_HALF_EN,
  output reg TIMER_SYSTEM_CLOCK_RUN,
  // wake sources
  input wire [NPIN-1:0] PIN_LEVEL,
  input wire [NPIN-1:0] PIN_DIGITAL_INPUT_ENABLE,
  input wire [NPIN-1:0] PIN_DIRECTION_CTRL,
  input wire TIMER_MATCH,
  input wire TIMER_ON_SYSTEM_CLOCK,
  input wire COMP_EVENT,
  input wire COMPARATOR_CONTROL7,
  input wire COMPARATOR_SELECT6
);
  localparam ST_ON = 2'b00;
  localparam ST_SAVE = 2'b01;
  localparam ST_DOWN = 2'b10;

  // ****************************************
  // reset synchroniser and sources
  // ****************************************
  // release passes two flops so every block leaves reset on one edge
  reg arst_s1_r;
  reg rst_n_r;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      arst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      arst_s1_r <= 1'b1;
      rst_n_r <= arst_s1_r;
    end
  end

  wire por_n_s;
  wire lvd_s;
  wire pin_s;
  wire tick_s;
  wire [NPIN-1:0] pins_s;
  rwpc_sync2 #(.RESET_VAL(1'b0)) u_por (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .d(POR_N),
    .q(por_n_s)
  );
  rwpc_sync2 #(.RESET_VAL(1'b0)) u_lvd (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .d(LOW_VOLTAGE_DET),
    .q(lvd_s)
  );
  // the pin idles high, so its stages reset high: no false pin reset
  rwpc_sync2 #(.RESET_VAL(1'b1)) u_pin (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .d(SHARED_RESET_IO_PIN),
    .q(pin_s)
  );
  rwpc_sync2 #(.RESET_VAL(1'b0)) u_tick (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .d(LOW_SPEED_RC_TICK),
    .q(tick_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      rwpc_sync2 #(.RESET_VAL(1'b0)) u_ps (
        .clk(CLK_SYS),
        .rst_n(rst_n_r),
        .d(PIN_LEVEL[gi]),
        .q(pins_s[gi])
      );
    end
  endgenerate

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] clk_mode_r;
  reg [7:0] misc_r;
  reg [7:0] eosc_r;
  reg [3:0] cause_r;
  reg [3:0] cause_nxt;
  reg sys_rst_q;
  reg [3:0] hold_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg tick_d_r;
  reg [NPIN-1:0] pins_d_r;
  wire wdt_expire;
  wire [`RWPC_WDT_W-1:0] wdt_count;

  wire wr = AVS_WRITE && !AVS_READ;
  wire lvr_hit = lvd_s && !misc_r[`RWPC_MISC_LVR_DIS] &&
    !eosc_r[`RWPC_EOSC_BG_PD];
  wire pin_hit = clk_mode_r[`RWPC_CM_PIN_SEL] && !pin_s;
  wire por_hit = !por_n_s;
  wire any_hit = por_hit || lvr_hit || wdt_expire || pin_hit;

  always @* begin
    cause_nxt = 4'h0;
    cause_nxt[`RWPC_CAUSE_POR] = por_hit;
    cause_nxt[`RWPC_CAUSE_LVR] = lvr_hit;
    cause_nxt[`RWPC_CAUSE_WDT] = wdt_expire;
    cause_nxt[`RWPC_CAUSE_PIN] = pin_hit;
  end

  // reset request held a few cycles so the cpu sees a clean pulse
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sys_rst_q <= 1'b1;
      hold_r <= `RWPC_RST_HOLD;
      cause_r <= `RWPC_CAUSE_RST;
    end else if (any_hit) begin
      sys_rst_q <= 1'b1;
      hold_r <= `RWPC_RST_HOLD;
      cause_r <= cause_nxt;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end else begin
      sys_rst_q <= 1'b0;
    end
  end

  // registers return to defaults on every system reset
  // writes are dropped while the reset request is held
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_mode_r <= `RWPC_CLK_MODE_RST;
      misc_r <= `RWPC_MISC_RST;
      eosc_r <= `RWPC_EOSC_RST;
    end else if (sys_rst_q) begin
      clk_mode_r <= `RWPC_CLK_MODE_RST;
      misc_r <= `RWPC_MISC_RST;
      eosc_r <= `RWPC_EOSC_RST;
    end else if (wr) begin
      case (AVS_ADDRESS)
        `RWPC_OFS_CLK_MODE: clk_mode_r <= AVS_WRITEDATA[7:0];
        `RWPC_OFS_MISC: misc_r <= AVS_WRITEDATA[7:0] &
          `RWPC_MISC_WMASK;
        `RWPC_OFS_EOSC: eosc_r <= AVS_WRITEDATA[7:0] &
          `RWPC_EOSC_WMASK;
        default: clk_mode_r <= clk_mode_r;
      endcase
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  wire lrc_en = clk_mode_r[`RWPC_CM_LRC_EN];
  wire tick_rise = tick_s && !tick_d_r;
  wire wdt_run = clk_mode_r[`RWPC_CM_WDT_EN] && lrc_en &&
    state_r != ST_DOWN;
  rwpc_wdt #(.W(`RWPC_WDT_W)) u_wdt (
    .clk(CLK_SYS),
    .rst_n(rst_n_r),
    .tick(tick_rise),
    .enable(wdt_run && !sys_rst_q),
    .clear(WDT_CLEAR || sys_rst_q),
    .period_sel(misc_r[`RWPC_MISC_WDT_HI:`RWPC_MISC_WDT_LO]),
    .expire(wdt_expire),
    .count(wdt_count)
  );

  // ****************************************
  // power modes and wake-up
  // ****************************************
  // a toggle compares the synchronised level with its previous sample
  wire [NPIN-1:0] toggled = pins_s ^ pins_d_r;
  wire wake_save = |(toggled & PIN_DIGITAL_INPUT_ENABLE &
    PIN_DIRECTION_CTRL) ||
    (TIMER_MATCH && !TIMER_ON_SYSTEM_CLOCK) ||
    (COMP_EVENT && COMPARATOR_CONTROL7 && COMPARATOR_SELECT6);
  wire wake_down = |(toggled & PIN_DIGITAL_INPUT_ENABLE);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ON: begin
        if (SLEEP_DOWN)
          state_nxt = ST_DOWN;
        else if (SLEEP_SAVE)
          state_nxt = ST_SAVE;
      end
      ST_SAVE: begin
        if (wake_save)
          state_nxt = ST_ON;
      end
      ST_DOWN: begin
        if (wake_down)
          state_nxt = ST_ON;
      end
      default: state_nxt = ST_ON;
    endcase
  end

  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_ON;
      tick_d_r <= 1'b0;
      pins_d_r <= {NPIN{1'b0}};
    end else begin
      state_r <= sys_rst_q ? ST_ON : state_nxt;
      tick_d_r <= tick_s;
      pins_d_r <= pins_s;
    end
  end

  // ****************************************
  // outputs, all registered
  // ****************************************
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      SYS_RESET <= 1'b1;
      PC_RESET_ZERO <= 1'b1;
      DMEM_UNDEFINED <= 1'b1;
      CPU_HALT <= 1'b0;
      CPU_RESUME <= 1'b0;
      SYSTEM_CLOCK_GATE_N <= 1'b1;
      PROG_MEM_ON <= 1'b1;
      LOW_SPEED_RC_ON <= 1'b1;
      HIGH_SPEED_RC_ON <= 1'b1;
      XTAL_ON <= 1'b0;
      XTAL_TYPE <= 2'b00;
      BANDGAP_PD <= 1'b0;
      BIAS_HALF_EN <= 1'b0;
      TIMER_SYSTEM_CLOCK_RUN <= 1'b1;
    end else begin
      SYS_RESET <= sys_rst_q;
      PC_RESET_ZERO <= sys_rst_q;
      // power-on/low-voltage mark memory undefined, others keep it
      DMEM_UNDEFINED <= sys_rst_q &&
        (cause_r[`RWPC_CAUSE_POR] || cause_r[`RWPC_CAUSE_LVR]);
      CPU_HALT <= state_nxt != ST_ON;
      CPU_RESUME <= state_r != ST_ON && state_nxt == ST_ON &&
        !sys_rst_q;
      SYSTEM_CLOCK_GATE_N <= state_nxt == ST_ON;
      PROG_MEM_ON <= state_nxt == ST_ON;
      LOW_SPEED_RC_ON <= (lrc_en || state_nxt == ST_SAVE) &&
        state_nxt != ST_DOWN;
      HIGH_SPEED_RC_ON <= clk_mode_r[`RWPC_CM_HRC_EN] &&
        state_nxt != ST_DOWN;
      XTAL_ON <= eosc_r[`RWPC_EOSC_XTAL_EN] && state_nxt != ST_DOWN;
      XTAL_TYPE <= eosc_r[`RWPC_EOSC_TYPE_HI:`RWPC_EOSC_TYPE_LO];
      BANDGAP_PD <= eosc_r[`RWPC_EOSC_BG_PD];
      BIAS_HALF_EN <= misc_r[`RWPC_MISC_BIAS_EN];
      TIMER_SYSTEM_CLOCK_RUN <= state_nxt == ST_ON;
    end
  end

  // ****************************************
  // avalon read path, one wait state
  // ****************************************
  // reads wait one cycle so that read data leave a flip-flop
  reg rd_done_r;
  reg [31:0] rd_nxt;
  assign AVS_WAITREQUEST = AVS_READ && !rd_done_r;
  always @* begin
    case (AVS_ADDRESS)
      `RWPC_OFS_CLK_MODE: rd_nxt = {24'h000000, clk_mode_r};
      `RWPC_OFS_STATUS: rd_nxt = {wdt_count[13:0], 12'h000,
        state_r, cause_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end
  always @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_done_r <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else begin
      rd_done_r <= AVS_READ && !rd_done_r;
      if (AVS_READ && !rd_done_r) begin
        AVS_READDATA <= rd_nxt;
      end
    end
  end
endmodule

// File: testbench/rwpc_chk_sva.sv
// concurrent checks on the reset and power-mode controller ports
`timescale 1ns/10ps
module rwpc_chk (
  // clock, reset and bus
  input wire CLK_SYS, input wire ARST_N, input wire AVS_WRITE,
  input wire [7:0] AVS_ADDRESS, input wire [31:0] AVS_WRITEDATA,
  // sources and strobes
  input wire POR_N, input wire LOW_VOLTAGE_DET, input wire SLEEP_SAVE,
  input wire SHARED_RESET_IO_PIN, input wire SLEEP_DOWN,
  // outputs under check
  input wire SYS_RESET, input wire PC_RESET_ZERO, input wire CPU_HALT,
  input wire CPU_RESUME, input wire SYSTEM_CLOCK_GATE_N,
  input wire PROG_MEM_ON, input wire LOW_SPEED_RC_ON, input wire XTAL_ON,
  input wire HIGH_SPEED_RC_ON, input wire [1:0] XTAL_TYPE,
  input wire BANDGAP_PD, input wire BIAS_HALF_EN, input wire TIMER_SYSTEM_CLOCK_RUN
);
  // shadow of written bits: xtal type, bandgap off, bias on
  reg [3:0] fld_r;
  reg sup_r;
  reg pin_r;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      {fld_r, sup_r, pin_r} <= 6'h00;
    else if (SYS_RESET)
      {fld_r, sup_r, pin_r} <= 6'h00;
    else if (AVS_WRITE && AVS_ADDRESS == 8'h0A)
      fld_r[3:1] <= {AVS_WRITEDATA[6:5], AVS_WRITEDATA[0]};
    else if (AVS_WRITE && AVS_ADDRESS == 8'h08)
      {fld_r[0], sup_r} <= {AVS_WRITEDATA[4], AVS_WRITEDATA[2]};
    else if (AVS_WRITE && AVS_ADDRESS == 8'h03)
      pin_r <= AVS_WRITEDATA[0];
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence s_save_go;
    SLEEP_SAVE && !CPU_HALT && !SYS_RESET;
  endsequence
  sequence s_down_go;
    SLEEP_DOWN && !CPU_HALT && !SYS_RESET;
  endsequence
  sequence s_saved;
    CPU_HALT && !SYSTEM_CLOCK_GATE_N && !PROG_MEM_ON && LOW_SPEED_RC_ON
      && !TIMER_SYSTEM_CLOCK_RUN;
  endsequence
  sequence s_downed;
    CPU_HALT && !PROG_MEM_ON && !LOW_SPEED_RC_ON && !HIGH_SPEED_RC_ON
      && !XTAL_ON;
  endsequence
  a_por_reset: assert property (!POR_N [*3] |-> ##[0:3] SYS_RESET)
    else $error("power-on request gave no reset");
  a_pc_zero: assert property (SYS_RESET == PC_RESET_ZERO &&
    (!SYS_RESET || !$past(SYS_RESET) ||
    (!XTAL_ON && !BANDGAP_PD && !BIAS_HALF_EN)))
    else $error("pc zero differs from system reset");
  a_drop_reset: assert property (
    (LOW_VOLTAGE_DET && !sup_r && !fld_r[1]) [*3] |-> ##[0:3] SYS_RESET)
    else $error("supply drop gave no reset");
  a_pin_reset: assert property (
    (pin_r && !SHARED_RESET_IO_PIN) [*3] |-> ##[0:3] SYS_RESET)
    else $error("low reset pin gave no reset");
  a_field_map: assert property (!SYS_RESET [*3] |->
    {XTAL_TYPE, BANDGAP_PD, BIAS_HALF_EN} inside {fld_r, $past(fld_r)})
    else $error("control outputs differ from written bits");
  a_save_enter: assert property (s_save_go |-> ##[1:2] s_saved)
    else $error("power-save state wrong");
  a_down_enter: assert property (s_down_go |-> ##[1:2] s_downed)
    else $error("power-down state wrong");
  a_resume_run: assert property (CPU_RESUME |->
    !SYS_RESET ##1 (!CPU_RESUME && !CPU_HALT))
    else $error("resume not a clean single pulse");
endmodule
bind rwpc_top rwpc_chk rwpc_chk_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_WRITEDATA(AVS_WRITEDATA), .POR_N(POR_N),
  .LOW_VOLTAGE_DET(LOW_VOLTAGE_DET), .SLEEP_SAVE(SLEEP_SAVE),
  .SHARED_RESET_IO_PIN(SHARED_RESET_IO_PIN), .SLEEP_DOWN(SLEEP_DOWN),
  .SYS_RESET(SYS_RESET), .PC_RESET_ZERO(PC_RESET_ZERO),
  .CPU_HALT(CPU_HALT), .CPU_RESUME(CPU_RESUME),
  .SYSTEM_CLOCK_GATE_N(SYSTEM_CLOCK_GATE_N), .PROG_MEM_ON(PROG_MEM_ON),
  .LOW_SPEED_RC_ON(LOW_SPEED_RC_ON), .XTAL_ON(XTAL_ON),
  .HIGH_SPEED_RC_ON(HIGH_SPEED_RC_ON), .XTAL_TYPE(XTAL_TYPE),
  .BANDGAP_PD(BANDGAP_PD), .BIAS_HALF_EN(BIAS_HALF_EN),
  .TIMER_SYSTEM_CLOCK_RUN(TIMER_SYSTEM_CLOCK_RUN));

// File: testbench/rwpc_cpu_model.sv
// behavioural cpu core issuing sleep and watchdog-clear strobes
`timescale 1ns/10ps
module rwpc_cpu_model (
  // clock
  input wire clk,
  // bench command: 1 clear, 2 power-save, 3 power-down
  input wire [1:0] cmd,
  input wire comp_on,
  // instruction strobes
  output reg wdt_clear,
  output reg sleep_save,
  output reg sleep_down,
  output reg comp_ctl7
);
  reg down_r;
  initial begin
    {wdt_clear, sleep_save, sleep_down, comp_ctl7, down_r} = 5'h00;
  end
  always @(posedge clk) begin
    wdt_clear <= (cmd == 2'h1);
    sleep_save <= (cmd == 2'h2);
    // comparator is switched off a cycle before the power-down strobe
    down_r <= (cmd == 2'h3);
    sleep_down <= down_r;
    comp_ctl7 <= comp_on && cmd != 2'h3 && !down_r;
  end
endmodule

// File: testbench/reset_wdt_power_mode_ctrl_tb_top.sv
// self-checking bench for the reset, watchdog and power-mode controller
`timescale 1ns/10ps
module reset_wdt_power_mode_ctrl_tb_top;
  localparam [63:0] TAB = 64'h03F6_0800_0A00_5500;
  reg CLK_SYS, ARST_N, AVS_READ, AVS_WRITE, POR_N, LOW_VOLTAGE_DET;
  reg LOW_SPEED_RC_TICK, SHARED_RESET_IO_PIN, TIMER_MATCH, TIMER_ON_SYSTEM_CLOCK;
  reg COMP_EVENT, COMPARATOR_SELECT6, comp_on, tick_on;
  reg [7:0] AVS_ADDRESS, PIN_LEVEL, PIN_DIGITAL_INPUT_ENABLE;
  reg [7:0] PIN_DIRECTION_CTRL, cm_m;
  reg [31:0] AVS_WRITEDATA, rnd, rd;
  reg [1:0] cpu_cmd;
  wire [31:0] AVS_READDATA;
  wire [1:0] XTAL_TYPE;
  wire AVS_WAITREQUEST, WDT_CLEAR, SLEEP_SAVE, SLEEP_DOWN, SYS_RESET;
  wire PC_RESET_ZERO, DMEM_UNDEFINED, CPU_HALT, CPU_RESUME, XTAL_ON;
  wire SYSTEM_CLOCK_GATE_N, PROG_MEM_ON, LOW_SPEED_RC_ON, BANDGAP_PD;
  wire HIGH_SPEED_RC_ON, BIAS_HALF_EN, TIMER_SYSTEM_CLOCK_RUN, COMPARATOR_CONTROL7;
  integer fail_count, checks_done, n, i, resumes, en_ticks;
  rwpc_top rwpc_top_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .POR_N(POR_N),
    .LOW_VOLTAGE_DET(LOW_VOLTAGE_DET), .LOW_SPEED_RC_TICK(LOW_SPEED_RC_TICK),
    .SHARED_RESET_IO_PIN(SHARED_RESET_IO_PIN), .WDT_CLEAR(WDT_CLEAR),
    .SLEEP_SAVE(SLEEP_SAVE), .SLEEP_DOWN(SLEEP_DOWN), .SYS_RESET(SYS_RESET),
    .PC_RESET_ZERO(PC_RESET_ZERO), .DMEM_UNDEFINED(DMEM_UNDEFINED),
    .CPU_HALT(CPU_HALT), .CPU_RESUME(CPU_RESUME),
    .SYSTEM_CLOCK_GATE_N(SYSTEM_CLOCK_GATE_N), .PROG_MEM_ON(PROG_MEM_ON),
    .LOW_SPEED_RC_ON(LOW_SPEED_RC_ON), .HIGH_SPEED_RC_ON(HIGH_SPEED_RC_ON),
    .XTAL_ON(XTAL_ON), .XTAL_TYPE(XTAL_TYPE), .BANDGAP_PD(BANDGAP_PD),
    .BIAS_HALF_EN(BIAS_HALF_EN), .TIMER_SYSTEM_CLOCK_RUN(TIMER_SYSTEM_CLOCK_RUN),
    .PIN_LEVEL(PIN_LEVEL),
    .PIN_DIGITAL_INPUT_ENABLE(PIN_DIGITAL_INPUT_ENABLE),
    .PIN_DIRECTION_CTRL(PIN_DIRECTION_CTRL), .TIMER_MATCH(TIMER_MATCH),
    .TIMER_ON_SYSTEM_CLOCK(TIMER_ON_SYSTEM_CLOCK), .COMP_EVENT(COMP_EVENT),
    .COMPARATOR_CONTROL7(COMPARATOR_CONTROL7),
    .COMPARATOR_SELECT6(COMPARATOR_SELECT6));
  rwpc_cpu_model rwpc_cpu_model_i (.clk(CLK_SYS), .cmd(cpu_cmd),
    .comp_on(comp_on), .wdt_clear(WDT_CLEAR), .sleep_save(SLEEP_SAVE),
    .sleep_down(SLEEP_DOWN), .comp_ctl7(COMPARATOR_CONTROL7));
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  // rc ticks; the model counts those seen while counting is enabled
  always @(posedge CLK_SYS) begin
    if (tick_on) begin
      LOW_SPEED_RC_TICK <= !LOW_SPEED_RC_TICK;
      if (!LOW_SPEED_RC_TICK && cm_m[1] && cm_m[2])
        en_ticks = en_ticks + 1;
    end
    if (CPU_RESUME === 1'b1)
      resumes = resumes + 1;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task complete_run;
    begin
      if (fail_count == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input c, input [8*24:1] m);
    begin
      checks_done = checks_done + 1;
      if (c !== 1'b1) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0t %0s", $time, m);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge CLK_SYS);
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge CLK_SYS);
      {AVS_ADDRESS, AVS_WRITEDATA} <= {a, d};
      {AVS_WRITE, AVS_READ} <= {w, !w};
      n = 0;
      @(posedge CLK_SYS);
      while (AVS_WAITREQUEST !== 1'b0 && n < 50) begin
        n = n + 1;
        @(posedge CLK_SYS);
      end
      if (n >= 50) begin
        chk(1'b0, "bus timeout");
        complete_run;
      end
      rd = AVS_READDATA;
      {AVS_WRITE, AVS_READ} <= 2'h0;
    end
  endtask
  task wait_sr(input v, input integer lim);
    begin
      n = 0;
      while (SYS_RESET !== v && n < lim) begin
        @(posedge CLK_SYS);
        n = n + 1;
      end
      if (n >= lim) begin
        chk(1'b0, "reset wait timeout");
        complete_run;
      end
    end
  endtask
  task slp(input [1:0] c);
    begin
      cpu_cmd <= c;
      cyc(1);
      cpu_cmd <= 2'h0;
      cyc(5);
    end
  endtask
  task tog;
    begin
      PIN_LEVEL <= ~PIN_LEVEL;
      cyc(6);
    end
  endtask
  initial begin
    {ARST_N, AVS_READ, AVS_WRITE, LOW_VOLTAGE_DET, LOW_SPEED_RC_TICK} = 0;
    {TIMER_MATCH, TIMER_ON_SYSTEM_CLOCK, COMP_EVENT, COMPARATOR_SELECT6} = 0;
    {comp_on, tick_on, cpu_cmd, AVS_WRITEDATA, AVS_ADDRESS} = 0;
    {PIN_LEVEL, PIN_DIGITAL_INPUT_ENABLE, PIN_DIRECTION_CTRL} = 0;
    {POR_N, SHARED_RESET_IO_PIN} = 2'h3;
    {fail_count, checks_done, resumes, en_ticks} = 0;
    {rnd, cm_m} = {32'hBF50, 8'hF6};
    cyc(8);
    ARST_N <= 1'b1;
    wait_sr(0, 100);
    POR_N <= 1'b0;
    wait_sr(1, 20);
    chk(DMEM_UNDEFINED === 1'b1, "power-on mem flag");
    POR_N <= 1'b1;
    wait_sr(0, 100);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = xs(rnd);
      bus(1, 8'h0A, {24'h0, rnd[7:0] & 8'hE1});
      bus(1, 8'h08, {24'h0, rnd[15:8] & 8'h17});
      cyc(2);
      chk({XTAL_ON, XTAL_TYPE, BANDGAP_PD} === {rnd[7:5], rnd[0]}, "osc");
      chk(BIAS_HALF_EN === rnd[12], "bias field");
    end
    bus(1, 8'h55, rnd);
    for (i = 0; i < 4; i = i + 1) begin
      bus(0, TAB[63-16*i -: 8], 0);
      chk(rd === {24'h0, TAB[55-16*i -: 8]}, "register image");
    end
    bus(1, 8'h03, 32'hF7);
    bus(1, 8'h0A, 0);
    bus(1, 8'h08, 32'h04);
    LOW_VOLTAGE_DET <= 1'b1;
    cyc(20);
    chk(SYS_RESET === 1'b0, "suppressed drop");
    bus(1, 8'h08, 0);
    wait_sr(1, 20);
    chk(DMEM_UNDEFINED === 1'b1, "drop mem flag");
    LOW_VOLTAGE_DET <= 1'b0;
    wait_sr(0, 100);
    bus(0, 8'h03, 0);
    chk(rd === 32'hF6, "defaults after reset");
    bus(1, 8'h03, 32'hF7);
    SHARED_RESET_IO_PIN <= 1'b0;
    wait_sr(1, 20);
    chk(DMEM_UNDEFINED === 1'b0, "pin keeps mem");
    wait_sr(0, 100);
    cyc(10);
    chk(SYS_RESET === 1'b0, "plain io pin");
    SHARED_RESET_IO_PIN <= 1'b1;
    tick_on <= 1'b1;
    cyc(12000);
    slp(2'h1);
    en_ticks = 0;
    cyc(6000);
    bus(1, 8'h03, 32'hF2);
    cm_m = 8'hF2;
    cyc(8000);
    chk(SYS_RESET === 1'b0, "clear and rc off");
    bus(1, 8'h03, 32'hF6);
    cm_m = 8'hF6;
    wait_sr(1, 12000);
    chk(en_ticks > 8188 && en_ticks < 8200, "timeout length");
    chk(DMEM_UNDEFINED === 1'b0, "timeout keeps mem");
    tick_on <= 1'b0;
    wait_sr(0, 100);
    bus(0, 8'h20, 0);
    chk(rd[5:0] === 6'h04, "watchdog cause status");
    comp_on <= 1'b1;
    slp(2'h2);
    chk(CPU_HALT === 1'b1 && LOW_SPEED_RC_ON === 1'b1, "save");
    chk(TIMER_SYSTEM_CLOCK_RUN === 1'b0, "system_clock timer run");
    {TIMER_ON_SYSTEM_CLOCK, TIMER_MATCH} <= 2'h3;
    cyc(6);
    chk(CPU_HALT === 1'b1, "system_clock timer woke");
    TIMER_ON_SYSTEM_CLOCK <= 1'b0;
    cyc(6);
    chk(resumes === 1 && CPU_HALT === 1'b0, "timer wake");
    TIMER_MATCH <= 1'b0;
    slp(2'h2);
    COMP_EVENT <= 1'b1;
    cyc(6);
    chk(CPU_HALT === 1'b1, "comp select off");
    COMPARATOR_SELECT6 <= 1'b1;
    cyc(6);
    chk(resumes === 2, "comp wake");
    {COMP_EVENT, PIN_DIGITAL_INPUT_ENABLE} <= 9'h0FF;
    slp(2'h2);
    tog;
    chk(CPU_HALT === 1'b1, "save needs direction");
    PIN_DIRECTION_CTRL <= 8'hFF;
    cyc(2);
    tog;
    chk(resumes === 3, "save pin wake");
    {TIMER_MATCH, PIN_DIRECTION_CTRL, PIN_DIGITAL_INPUT_ENABLE} <= 17'h10000;
    slp(2'h3);
    chk({HIGH_SPEED_RC_ON, LOW_SPEED_RC_ON} === 2'h0, "down osc");
    chk(CPU_HALT === 1'b1, "timer woke down");
    tog;
    chk(CPU_HALT === 1'b1, "disabled pin woke");
    PIN_DIGITAL_INPUT_ENABLE <= 8'h08;
    cyc(2);
    tog;
    chk(resumes === 4 && SYS_RESET === 1'b0, "down pin wake");
    complete_run;
  end
endmodule
